// ### svw_core.sv
/*
 * Supply supervisor and watchdog sequencer top level.
 * Assumes supply comparator levels and host inputs are synchronous to i_clk.
 */
`default_nettype none
`timescale 1ns/100ps

module svw_core #(
    parameter logic [15:0] INIT_TICKS       = svw_pkg::INIT_TICKS_DEF,
    parameter logic [15:0] POR_TICKS        = svw_pkg::POR_TICKS_DEF,
    parameter logic [15:0] WDT_TICKS        = svw_pkg::WDT_TICKS_DEF,
    parameter logic [15:0] DISCH_TICKS      = svw_pkg::DISCH_TICKS_DEF,
    parameter bit          KICK_RISING      = 1'b1,
    parameter bit          GATE_ACTIVE_HIGH = 1'b1
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_above_min,
    input  wire logic i_below_detect,
    input  wire logic i_above_release,
    input  wire logic i_gate,
    input  wire logic i_kick_in,
    output logic      o_reset_n,
    output logic      o_timeout_out_n,
    output logic      o_low_voltage
);
    svw_pkg::svw_state_type state_ff;
    svw_pkg::svw_state_type nxt_state;
    svw_pkg::svw_state_type prev_state_ff;
    logic [2:0]  por_cnt_ff;
    logic [4:0]  wd_cnt_ff;
    logic [4:0]  setup_cnt_ff;
    logic        kick_prev_ff;
    logic [15:0] limit;
    logic        tick_done;
    logic        gate_en;
    logic        kick_edge;
    logic        kick_ok;
    logic        setup_done;

    // Gate read live each cycle; no latched copy to disturb
    assign gate_en    = (i_gate == GATE_ACTIVE_HIGH);
    assign kick_edge  = KICK_RISING ? (i_kick_in && !kick_prev_ff)
                                    : (!i_kick_in && kick_prev_ff);
    assign setup_done = (setup_cnt_ff == 5'(svw_pkg::SETUP_CYCLES));
    assign kick_ok    = kick_edge && setup_done;

    always_comb begin
        case (state_ff)
            svw_pkg::ST_INIT:  limit = INIT_TICKS;
            svw_pkg::ST_RUN:   limit = WDT_TICKS;
            svw_pkg::ST_DISCH: limit = DISCH_TICKS;
            default:           limit = POR_TICKS;
        endcase
    end

    svw_tick_timer u_timer (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_restart (nxt_state != state_ff),
        .i_limit   (limit),
        .o_done    (tick_done)
    );

    always_comb begin
        nxt_state = state_ff;
        if (!i_above_min) begin
            nxt_state = svw_pkg::ST_OFF;
        end else if (i_below_detect) begin
            nxt_state = svw_pkg::ST_LOW;
        end else begin
            case (state_ff)
                svw_pkg::ST_OFF: begin
                    nxt_state = svw_pkg::ST_LOW;
                end
                svw_pkg::ST_LOW: begin
                    // Held here between detection and release on the way up
                    if (i_above_release) begin
                        nxt_state = svw_pkg::ST_INIT;
                    end
                end
                svw_pkg::ST_INIT: begin
                    if (tick_done) begin
                        nxt_state = svw_pkg::ST_POR;
                    end
                end
                svw_pkg::ST_POR: begin
                    if (tick_done && por_cnt_ff == 3'(svw_pkg::POR_CYCLES - 1)) begin
                        nxt_state = gate_en ? svw_pkg::ST_RUN : svw_pkg::ST_IDLE;
                    end
                end
                svw_pkg::ST_IDLE: begin
                    if (gate_en) begin
                        nxt_state = svw_pkg::ST_RUN;
                    end
                end
                svw_pkg::ST_RUN: begin
                    if (!gate_en || kick_ok) begin
                        nxt_state = svw_pkg::ST_DISCH;
                    end else if (tick_done && wd_cnt_ff == 5'(svw_pkg::WD_CYCLES - 1)) begin
                        nxt_state = svw_pkg::ST_TIMEOUT;
                    end
                end
                svw_pkg::ST_DISCH: begin
                    if (tick_done) begin
                        nxt_state = gate_en ? svw_pkg::ST_RUN : svw_pkg::ST_IDLE;
                    end
                end
                svw_pkg::ST_TIMEOUT: begin
                    // Low pulse lasts one power-on cycle, then cycling restarts
                    if (tick_done) begin
                        nxt_state = gate_en ? svw_pkg::ST_RUN : svw_pkg::ST_IDLE;
                    end
                end
                default: nxt_state = svw_pkg::ST_LOW;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff      <= svw_pkg::STATE_RST;
            prev_state_ff <= svw_pkg::STATE_RST;
        end else if (i_ce) begin
            state_ff      <= nxt_state;
            prev_state_ff <= state_ff;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            por_cnt_ff <= 3'h0;
        end else if (i_ce) begin
            if (state_ff != svw_pkg::ST_POR) begin
                por_cnt_ff <= 3'h0;
            end else if (tick_done) begin
                por_cnt_ff <= por_cnt_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wd_cnt_ff <= 5'h00;
        end else if (i_ce) begin
            if (state_ff != svw_pkg::ST_RUN || nxt_state != svw_pkg::ST_RUN) begin
                wd_cnt_ff <= 5'h00;
            end else if (tick_done) begin
                wd_cnt_ff <= wd_cnt_ff + 5'h01;
            end
        end
    end

    // Setup window restarts each time the gate is disabled
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            setup_cnt_ff <= 5'h00;
            kick_prev_ff <= 1'b0;
        end else if (i_ce) begin
            kick_prev_ff <= i_kick_in;
            if (!gate_en) begin
                setup_cnt_ff <= 5'h00;
            end else if (!setup_done) begin
                setup_cnt_ff <= setup_cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reset_n       <= 1'b0;
            o_timeout_out_n <= 1'b0;
            o_low_voltage   <= 1'b0;
        end else if (i_ce) begin
            o_reset_n       <= !(nxt_state inside {svw_pkg::ST_LOW, svw_pkg::ST_INIT, svw_pkg::ST_POR});
            o_timeout_out_n <= !(nxt_state inside {svw_pkg::ST_LOW, svw_pkg::ST_INIT, svw_pkg::ST_POR,
                                                   svw_pkg::ST_TIMEOUT});
            o_low_voltage   <= (nxt_state == svw_pkg::ST_LOW);
        end
    end

    property p_low_voltage;
        @(posedge i_clk) disable iff (i_rst)
        i_ce && i_above_min && i_below_detect |=> !o_reset_n && !o_timeout_out_n && o_low_voltage;
    endproperty
    a_low_voltage: assert property (p_low_voltage)
        else $error("Low voltage did not pull both outputs low");

    property p_below_min;
        @(posedge i_clk) disable iff (i_rst)
        i_ce && !i_above_min |=> o_reset_n;
    endproperty
    a_below_min: assert property (p_below_min)
        else $error("Reset output not released below minimum voltage");

    property p_rise_hold;
        @(posedge i_clk) disable iff (i_rst)
        i_ce && state_ff == svw_pkg::ST_LOW && i_above_min && !i_below_detect && !i_above_release
            |=> !o_reset_n;
    endproperty
    a_rise_hold: assert property (p_rise_hold)
        else $error("Reset released before release threshold");

    property p_por_after_init;
        @(posedge i_clk) disable iff (i_rst)
        state_ff == svw_pkg::ST_POR && prev_state_ff != svw_pkg::ST_POR |-> prev_state_ff == svw_pkg::ST_INIT;
    endproperty
    a_por_after_init: assert property (p_por_after_init)
        else $error("Power-on cycling began without init delay");

    property p_release_after_por;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_reset_n) && state_ff != svw_pkg::ST_OFF |-> prev_state_ff == svw_pkg::ST_POR && $past(por_cnt_ff) == 3'h3;
    endproperty
    a_release_after_por: assert property (p_release_after_por)
        else $error("Reset released without four power-on cycles");

    property p_timeout_count;
        @(posedge i_clk) disable iff (i_rst)
        $past(i_ce) && state_ff == svw_pkg::ST_TIMEOUT && prev_state_ff == svw_pkg::ST_RUN
            |-> $past(wd_cnt_ff) == 5'h1f && !o_timeout_out_n;
    endproperty
    a_timeout_count: assert property (p_timeout_count)
        else $error("Timeout not after thirty-two cycles");

    property p_kick_clears;
        @(posedge i_clk) disable iff (i_rst)
        state_ff == svw_pkg::ST_DISCH |-> wd_cnt_ff == 5'h00;
    endproperty
    a_kick_clears: assert property (p_kick_clears)
        else $error("Cycle counter not cleared during discharge");

    property p_setup_ignore;
        @(posedge i_clk) disable iff (i_rst)
        i_ce && state_ff == svw_pkg::ST_RUN && gate_en && kick_edge && !setup_done && i_above_min && !i_below_detect
            && !(tick_done && wd_cnt_ff == 5'h1f)
            |=> state_ff == svw_pkg::ST_RUN;
    endproperty
    a_setup_ignore: assert property (p_setup_ignore)
        else $error("Kick accepted inside setup interval");

    property p_gate_start;
        @(posedge i_clk) disable iff (i_rst)
        i_ce && state_ff == svw_pkg::ST_IDLE && gate_en && i_above_min && !i_below_detect
            |=> state_ff == svw_pkg::ST_RUN;
    endproperty
    a_gate_start: assert property (p_gate_start)
        else $error("Idle watchdog did not start on gate enable");

    property p_gate_off;
        @(posedge i_clk) disable iff (i_rst)
        i_ce && state_ff == svw_pkg::ST_RUN && !gate_en && i_above_min && !i_below_detect
            |=> state_ff == svw_pkg::ST_DISCH && wd_cnt_ff == 5'h00;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("Gate disable did not force discharge");
endmodule

`default_nettype wire

// ### svw_host_model.sv
/*
 * Host-side model: drives the watchdog gate and kick lines of the core.
 * Assumes bench commands are levels updated at falling clock edges.
 */
`default_nettype none
`timescale 1ns/100ps

module svw_host_model #(
    parameter bit GATE_ACTIVE_HIGH = 1'h1
) (
    input  wire logic i_clk,
    input  wire logic i_gate_req,
    input  wire logic i_kick_req,
    output logic      o_gate,
    output logic      o_kick_in
);
    logic [1:0] pulse_ff = 2'h0;

    // Two-cycle pulse: both edge polarities appear, so either variant sees one
    always_ff @(negedge i_clk) begin
        if (i_kick_req) begin
            pulse_ff <= 2'h2;
        end else if (pulse_ff != 2'h0) begin
            pulse_ff <= pulse_ff - 2'h1;
        end
    end

    assign o_kick_in = (pulse_ff != 2'h0);
    assign o_gate    = i_gate_req ~^ GATE_ACTIVE_HIGH;
endmodule

`default_nettype wire

// ### svw_tick_timer.sv
/*
 * Constants for the supervisor and watchdog core, and the phase tick timer.
 * Assumes one clock, an asynchronous active-high reset and a clock enable.
 */
`default_nettype none

package svw_pkg;
    localparam int unsigned TICK_W        = 16;
    localparam int unsigned POR_CYCLES    = 4;
    localparam int unsigned WD_CYCLES     = 32;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SETUP_TIME_NS = 1000;
    // Longest time, so rounded down
    localparam int unsigned SETUP_CYCLES  = (SETUP_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
                                          : (SETUP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [15:0] INIT_TICKS_DEF  = 16'h0014;
    localparam logic [15:0] POR_TICKS_DEF   = 16'h0064;
    localparam logic [15:0] WDT_TICKS_DEF   = 16'h0032;
    localparam logic [15:0] DISCH_TICKS_DEF = 16'h0004;

    typedef enum logic [2:0] {
        ST_LOW     = 3'h0,
        ST_INIT    = 3'h1,
        ST_POR     = 3'h3,
        ST_RUN     = 3'h2,
        ST_DISCH   = 3'h6,
        ST_TIMEOUT = 3'h7,
        ST_IDLE    = 3'h5,
        ST_OFF     = 3'h4
    } svw_state_type;

    localparam svw_state_type STATE_RST = ST_LOW;
endpackage

`timescale 1ns/100ps

module svw_tick_timer (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_restart,
    input  wire logic [15:0] i_limit,
    output logic             o_done
);
    logic [15:0] cnt_ff;

    // Zero limit would wrap to all ones; treated as one tick
    assign o_done = (i_limit <= 16'h0001) || (cnt_ff >= i_limit - 16'h0001);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= 16'h0000;
        end else if (i_ce) begin
            if (i_restart || o_done) begin
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
endmodule

`default_nettype wire

// ### test_supervisor_watchdog_core.sv
/*
 * Self-checking bench for the supervisor and watchdog core.
 * Assumes the host model file and the design files are compiled first.
 */
`default_nettype none
`timescale 1ns/100ps

module test_supervisor_watchdog_core;
    localparam logic [15:0] INIT_T = 16'h0004;
    localparam logic [15:0] POR_T  = 16'h0008;
    localparam int          T_REL  = int'(INIT_T) + svw_pkg::POR_CYCLES * int'(POR_T);
    localparam int          T_WD   = svw_pkg::WD_CYCLES * 4;

    logic i_clk;
    logic i_rst = 1'h1;
    logic i_ce = 1'h1;
    logic above_min = 1'h1;
    logic below_det = 1'h0;
    logic above_rel = 1'h0;
    logic gate_req = 1'h1;
    logic kick_req = 1'h0;
    wire logic gate;
    wire logic kick;
    wire logic rst_n;
    wire logic to_n;
    wire logic lv;
    wire logic gate_f;
    wire logic kick_f;
    wire logic to_n_f;
    int bad_count = 0;
    int n_tests = 0;
    int seed = 93;
    int n;
    int r;

    svw_host_model host (.i_clk(i_clk), .i_gate_req(gate_req), .i_kick_req(kick_req), .o_gate(gate), .o_kick_in(kick));

    svw_core #(.INIT_TICKS(INIT_T), .POR_TICKS(POR_T), .WDT_TICKS(16'h0004), .DISCH_TICKS(16'h0002)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_above_min(above_min), .i_below_detect(below_det),
        .i_above_release(above_rel), .i_gate(gate), .i_kick_in(kick), .o_reset_n(rst_n),
        .o_timeout_out_n(to_n), .o_low_voltage(lv));

    // Second variant: falling kick edge, active-low gate, same commands
    svw_host_model #(.GATE_ACTIVE_HIGH(1'h0)) host_f (.i_clk(i_clk), .i_gate_req(gate_req), .i_kick_req(kick_req),
        .o_gate(gate_f), .o_kick_in(kick_f));

    svw_core #(.INIT_TICKS(INIT_T), .POR_TICKS(POR_T), .WDT_TICKS(16'h0004), .DISCH_TICKS(16'h0002),
               .KICK_RISING(1'b0), .GATE_ACTIVE_HIGH(1'b0)) DUT_FALL (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_above_min(above_min), .i_below_detect(below_det),
        .i_above_release(above_rel), .i_gate(gate_f), .i_kick_in(kick_f), .o_reset_n(),
        .o_timeout_out_n(to_n_f), .o_low_voltage());

    initial begin
        i_clk = 1'h0;
        forever #20 i_clk = ~i_clk;
    end

    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    function logic pick(input int sel);
        return (sel == 0) ? rst_n : (sel == 1) ? to_n : lv;
    endfunction

    task step(input int c);
        repeat (c) @(negedge i_clk);
    endtask

    // Bounded wait; the cycle count must land in the window
    task wait_for(input int sel, input logic val, input int lo, input int hi, input string what);
        n = 0;
        while (pick(sel) !== val && n < hi + 8) begin
            @(negedge i_clk);
            n++;
        end
        check(what, (n >= lo && n <= hi), 1);
    endtask

    task hold(input int sel, input logic val, input int cyc, input string what);
        int miss;
        miss = 0;
        repeat (cyc) begin
            @(negedge i_clk);
            if (pick(sel) !== val) miss++;
        end
        check(what, miss, 0);
    endtask

    task kick_once;
        @(negedge i_clk) kick_req <= 1'h1;
        @(negedge i_clk) kick_req <= 1'h0;
    endtask

    initial begin
        step(2);
        i_rst <= 1'h0;
        hold(0, 1'h0, 20, "reset_n below release");
        above_rel <= 1'h1;
        wait_for(0, 1'h1, T_REL - 2, T_REL + 3, "power-up release delay");
        check("timeout_n at release", to_n, 1);
        $display("power-up test done");
        wait_for(1, 1'h0, T_WD - 3, T_WD + 3, "unkicked timeout");
        check("reset_n during timeout", rst_n, 1);
        wait_for(1, 1'h1, 1, int'(POR_T) + 3, "timeout recovery");
        // Ordinary kicks stay well past the gate setup interval
        step(30);
        repeat (8) begin
            kick_once();
            r = {$random(seed)} % 90;
            hold(1, 1'h1, 20 + r, "kicked timeout_n");
        end
        kick_once();
        wait_for(1, 1'h0, T_WD + 1, T_WD + 6, "timeout after kick");
        // Falling variant sees the kick two cycles after the rising one
        check("falling variant before timeout", to_n_f, 1);
        step(2);
        check("falling variant timeout", to_n_f, 0);
        wait_for(1, 1'h1, 1, int'(POR_T) + 3, "timeout recovery");
        $display("kick test done");
        step(40);
        gate_req <= 1'h0;
        hold(1, 1'h1, T_WD + 20, "gate off in run");
        gate_req <= 1'h1;
        step(5);
        kick_once();
        wait_for(1, 1'h0, T_WD - 12, T_WD - 2, "early kick ignored");
        wait_for(1, 1'h1, 1, int'(POR_T) + 3, "timeout recovery");
        $display("gate test done");
        step(10);
        above_rel <= 1'h0;
        hold(0, 1'h1, 30, "reset_n between thresholds");
        below_det <= 1'h1;
        step(1);
        check("low voltage flag", lv, 1);
        check("reset_n on low voltage", rst_n, 0);
        check("timeout_n on low voltage", to_n, 0);
        below_det <= 1'h0;
        hold(0, 1'h0, 20, "reset_n above detect");
        above_rel <= 1'h1;
        wait_for(0, 1'h1, T_REL - 2, T_REL + 3, "release after low voltage");
        wait_for(1, 1'h0, T_WD - 3, T_WD + 3, "gate kept over low voltage");
        wait_for(1, 1'h1, 1, int'(POR_T) + 3, "timeout recovery");
        $display("low voltage test done");
        // Frozen clock enable must hold the watchdog count still
        i_ce <= 1'h0;
        hold(1, 1'h1, T_WD + 20, "timeout_n while frozen");
        i_ce <= 1'h1;
        $display("freeze test done");
        above_min <= 1'h0;
        below_det <= 1'h1;
        above_rel <= 1'h0;
        step(1);
        check("reset_n below minimum", rst_n, 1);
        above_min <= 1'h1;
        step(1);
        check("reset_n above minimum", rst_n, 0);
        check("low voltage above minimum", lv, 1);
        below_det <= 1'h0;
        gate_req <= 1'h0;
        step(5);
        above_rel <= 1'h1;
        wait_for(0, 1'h1, T_REL - 2, T_REL + 3, "release with gate off");
        hold(1, 1'h1, T_WD + 20, "idle with gate off");
        gate_req <= 1'h1;
        wait_for(1, 1'h0, T_WD - 3, T_WD + 3, "gate on from idle");
        $display("brownout test done");
        end_sim();
    end

    // Whole sequence needs under 3000 cycles
    initial begin
        #(40 * 20000);
        bad_count++;
        end_sim();
    end
endmodule

`default_nettype wire
